// >>> rtl/bridge_primary_config_header.sv
// Primary-side configuration header of the bridge: status, class, line size, tenure timer.
// Assumes configuration cycles from the primary target logic on the primary clock,
// and event strobes from the primary master and target logic on that clock.
//
// Overview of operation
// - Writing one clears a flag; zero keeps.
// - Status bits 19:16 and 22 read zero.
// - Bit 20 shows capability list presence.
// - Bit 21 follows the fast clock strap.
// - Bit 23 always reads one.
// - Bit 24 set on master parity, when enabled.
// - Bits 26:25 read 01b, medium select.
// - Bit 27 set on target abort signalled.
// - Bit 28 set on target abort received.
// - Bit 29 set on master abort.
// - Bit 30 set when system error driven.
// - Bit 31 set on any detected data or address parity error.
// - Revision byte fixed per silicon revision.
// - Programming interface byte reads zero.
// - Subclass byte reads 04h.
// - Base class byte reads 06h.
// - Line size writable, steers prefetch and bursts.
// - Bad or oversized line size acts as zero.
// - Tenure timer writable, counts clocks from frame.
// - Zero timer releases after first transfer once grant is lost.
// - Parity response enables error signalling outputs.
`timescale 1ns/1ps
module bridge_primary_config_header #(
    parameter logic [7:0] REVISION = 8'h00,
    parameter bit CAP_LIST_PRESENT = 1'b1
) (
    input wire logic CLK_SYS_I,
    input wire logic RESET_N_I,
    input wire logic CFG_RD_I,
    input wire logic CFG_WR_I,
    input wire logic [bridge_cfg_pkg::ADDR_W-1:0] CFG_ADDR_I,
    input wire logic [bridge_cfg_pkg::LANES-1:0] CFG_BE_N_I,
    input wire logic [bridge_cfg_pkg::DATA_W-1:0] CFG_WDATA_I,
    output logic [bridge_cfg_pkg::DATA_W-1:0] CFG_RDATA_O,
    output logic CFG_ACK_O,
    input wire logic FAST_CLOCK_STRAP_I,
    input wire logic PARITY_RESP_EN_I,
    input wire logic MASTER_ACTIVE_I,
    input wire logic PERR_SEEN_I,
    input wire logic DATA_PERR_I,
    input wire logic ADDR_PERR_I,
    input wire logic TGT_ABORT_SENT_I,
    input wire logic TGT_ABORT_RCVD_I,
    input wire logic MST_ABORT_I,
    input wire logic FRAME_START_I,
    input wire logic GRANT_I,
    input wire logic MWI_I,
    input wire logic DATA_DONE_I,
    input wire logic LINE_BOUNDARY_I,
    output logic PERR_REQ_O,
    output logic SERR_REQ_O,
    output logic [bridge_cfg_pkg::BYTE_W-1:0] LINE_SIZE_EFF_O,
    output logic TENURE_EXPIRED_O,
    output logic BURST_STOP_O
);
    import bridge_cfg_pkg::*;

    status_evt_if flag_bus ();

    logic strap_s1_reg;
    logic strap_s2_reg;
    logic [7:0] line_size_reg;
    logic [7:0] line_size_next;
    logic [7:0] tenure_reg;
    logic [7:0] tenure_next;
    logic perr_req_reg;
    logic serr_req_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;
    logic ack_reg;

    // Decode of configuration cycles.
    logic [5:0] cfg_dword;
    logic hit_status;
    logic hit_class;
    logic hit_misc;
    logic wr_status_hi;
    logic wr_line_size;
    logic wr_tenure;
    logic line_size_ok;
    logic [DATA_W-1:0] status_word;
    logic [DATA_W-1:0] class_word;
    logic [DATA_W-1:0] misc_word;
    logic [FLAG_COUNT-1:0] flag_bits;

    assign cfg_dword = CFG_ADDR_I[7:2];
    assign hit_status = cfg_dword == dword_of(OFS_STATUS);
    assign hit_class = cfg_dword == dword_of(OFS_REVISION);
    assign hit_misc = cfg_dword == dword_of(OFS_LINE_SIZE);
    // Every W1C flag lives in the top byte lane of the status dword.
    assign wr_status_hi = CFG_WR_I && hit_status && !CFG_BE_N_I[FLAG_POS[0] / BYTE_W];
    assign wr_line_size = CFG_WR_I && hit_misc && !CFG_BE_N_I[lane_of(OFS_LINE_SIZE)];
    assign wr_tenure = CFG_WR_I && hit_misc && !CFG_BE_N_I[lane_of(OFS_TENURE)];

    // The strap is a pin, so it is synchronised before anything looks at it.
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            strap_s1_reg <= 1'b0;
            strap_s2_reg <= 1'b0;
        end else begin
            strap_s1_reg <= FAST_CLOCK_STRAP_I;
            strap_s2_reg <= strap_s1_reg;
        end
    end

    // Hardware events feeding the sticky flags, and write-one clears.
    assign flag_bus.set_evt[FLAG_DATA_PAR] = MASTER_ACTIVE_I && PARITY_RESP_EN_I &&
                                             (PERR_SEEN_I || DATA_PERR_I);
    assign flag_bus.set_evt[FLAG_SIG_TABORT] = TGT_ABORT_SENT_I;
    assign flag_bus.set_evt[FLAG_RCV_TABORT] = MASTER_ACTIVE_I && TGT_ABORT_RCVD_I;
    assign flag_bus.set_evt[FLAG_RCV_MABORT] = MASTER_ACTIVE_I && MST_ABORT_I;
    assign flag_bus.set_evt[FLAG_SIG_SERR] = serr_req_reg;
    // Detection is recorded even when reporting is disabled.
    assign flag_bus.set_evt[FLAG_DET_PAR] = DATA_PERR_I || ADDR_PERR_I;

    genvar gi;
    generate
        for (gi = 0; gi < FLAG_COUNT; gi++) begin : g_clr
            assign flag_bus.clr_mask[gi] = wr_status_hi && CFG_WDATA_I[FLAG_POS[gi]];
        end
    endgenerate

    status_flags u_status_flags (
        .clk_i(CLK_SYS_I),
        .reset_n_i(RESET_N_I),
        .evt_bus(flag_bus.keeper)
    );

    assign flag_bits = flag_bus.flags;

    // Error signalling requests are gated by the parity response enable.
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            perr_req_reg <= 1'b0;
            serr_req_reg <= 1'b0;
        end else begin
            perr_req_reg <= PARITY_RESP_EN_I && DATA_PERR_I;
            serr_req_reg <= PARITY_RESP_EN_I && ADDR_PERR_I;
        end
    end

    // Writable line size and tenure timer bytes.
    assign line_size_next = wr_line_size ? CFG_WDATA_I[lane_of(OFS_LINE_SIZE) * BYTE_W +: BYTE_W]
                                         : line_size_reg;
    assign tenure_next = wr_tenure ? CFG_WDATA_I[lane_of(OFS_TENURE) * BYTE_W +: BYTE_W]
                                   : tenure_reg;

    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            line_size_reg <= LINE_SIZE_RESET;
            tenure_reg <= TENURE_RESET;
        end else begin
            line_size_reg <= line_size_next;
            tenure_reg <= tenure_next;
        end
    end

    // Software may write anything; only powers of two up to the limit take effect.
    assign line_size_ok = (line_size_reg & (line_size_reg - 8'h01)) == 8'h00 &&
                          line_size_reg <= LINE_SIZE_MAX;
    assign LINE_SIZE_EFF_O = line_size_ok ? line_size_reg : 8'h00;

    tenure_timer #(
        .WIDTH(BYTE_W)
    ) u_tenure_timer (
        .clk_i(CLK_SYS_I),
        .reset_n_i(RESET_N_I),
        .timer_value_i(tenure_reg),
        .frame_start_i(FRAME_START_I),
        .master_active_i(MASTER_ACTIVE_I),
        .grant_i(GRANT_I),
        .mwi_i(MWI_I),
        .data_done_i(DATA_DONE_I),
        .line_boundary_i(LINE_BOUNDARY_I),
        .expired_o(TENURE_EXPIRED_O),
        .stop_o(BURST_STOP_O)
    );

    // Read images of the three mapped dwords; the command half reads zero here.
    always_comb begin
        status_word = READ_ZERO;
        status_word[BIT_CAP_LIST] = CAP_LIST_PRESENT;
        status_word[BIT_FAST_CLOCK] = strap_s2_reg;
        status_word[BIT_FAST_B2B] = 1'b1;
        status_word[DEVSEL_LSB +: 2] = DEVSEL_MEDIUM;
        for (int i = 0; i < FLAG_COUNT; i++) begin
            status_word[FLAG_POS[i]] = flag_bits[i];
        end
    end

    assign class_word = {BASECLASS_CODE, SUBCLASS_CODE, PROG_IF_CODE, REVISION};
    assign misc_word = {16'h0000, tenure_reg, line_size_reg};

    assign rdata_next = hit_status ? status_word :
                        hit_class ? class_word :
                        hit_misc ? misc_word : READ_ZERO;

    // Answers are registered and come one clock after the request.
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            rdata_reg <= READ_ZERO;
            ack_reg <= 1'b0;
        end else begin
            rdata_reg <= CFG_RD_I ? rdata_next : rdata_reg;
            ack_reg <= CFG_RD_I || CFG_WR_I;
        end
    end

    assign CFG_RDATA_O = rdata_reg;
    assign CFG_ACK_O = ack_reg;
    assign PERR_REQ_O = perr_req_reg;
    assign SERR_REQ_O = serr_req_reg;

    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!RESET_N_I);

    sequence s_status_read;
        CFG_RD_I && hit_status;
    endsequence

    sequence s_class_read;
        CFG_RD_I && hit_class;
    endsequence

    a_status_fixed_bits:
        assert property (s_status_read |=> CFG_ACK_O && CFG_RDATA_O[19:16] == 4'h0 &&
                         !CFG_RDATA_O[22])
        else $error("reserved status bits read nonzero");
    a_status_const_bits:
        assert property (s_status_read |=> CFG_RDATA_O[23] && CFG_RDATA_O[26:25] == 2'h1 &&
                         CFG_RDATA_O[20] == CAP_LIST_PRESENT)
        else $error("constant status bits read wrong");
    a_strap_visible:
        assert property (s_status_read |=> CFG_RDATA_O[21] == $past(strap_s2_reg))
        else $error("fast clock bit does not follow strap");
    a_class_codes:
        assert property (s_class_read |=> CFG_RDATA_O == {8'h06, 8'h04, 8'h00, REVISION})
        else $error("class dword read wrong");
    a_parity_gated:
        assert property (!PARITY_RESP_EN_I || !MASTER_ACTIVE_I ##0 !TGT_ABORT_SENT_I
                         ##0 flag_bits[FLAG_DATA_PAR] == 1'b0 |=>
                         !flag_bits[FLAG_DATA_PAR])
        else $error("data parity flag set while not enabled master");
    a_serr_records:
        assert property (PARITY_RESP_EN_I && ADDR_PERR_I |=> SERR_REQ_O ##1
                         flag_bits[FLAG_SIG_SERR])
        else $error("system error not recorded in status");
    a_detect_always:
        assert property (DATA_PERR_I || ADDR_PERR_I |=> flag_bits[FLAG_DET_PAR])
        else $error("detected parity flag not set");
    a_line_size_valid:
        assert property (LINE_SIZE_EFF_O != 8'h00 |-> LINE_SIZE_EFF_O <= 8'h10 &&
                         (LINE_SIZE_EFF_O & (LINE_SIZE_EFF_O - 8'h01)) == 8'h00)
        else $error("invalid line size reached the datapath");
    a_tenure_write:
        assert property (wr_tenure ##1 !CFG_WR_I ##1 CFG_RD_I && hit_misc && !CFG_WR_I |=>
                         CFG_RDATA_O[15:8] == $past(CFG_WDATA_I[15:8], 3))
        else $error("tenure timer did not take the written value");
    a_access_answer:
        assert property (CFG_RD_I || CFG_WR_I |=> CFG_ACK_O)
        else $error("configuration access not answered next cycle");
endmodule

// >>> inc/bridge_cfg_pkg.sv
// Constants for the primary-side configuration header of the bridge.
// Assumes configuration cycles present a byte address and active-low byte enables.
package bridge_cfg_pkg;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam int LANES = 4;
    localparam int BYTE_W = 8;
    // Byte offsets of the registers inside configuration space.
    localparam logic [7:0] OFS_STATUS = 8'h06;
    localparam logic [7:0] OFS_REVISION = 8'h08;
    localparam logic [7:0] OFS_PROG_IF = 8'h09;
    localparam logic [7:0] OFS_SUBCLASS = 8'h0A;
    localparam logic [7:0] OFS_BASECLASS = 8'h0B;
    localparam logic [7:0] OFS_LINE_SIZE = 8'h0C;
    localparam logic [7:0] OFS_TENURE = 8'h0D;
    // Bit positions within the status dword.
    localparam int BIT_CAP_LIST = 20;
    localparam int BIT_FAST_CLOCK = 21;
    localparam int BIT_FAST_B2B = 23;
    localparam int DEVSEL_LSB = 25;
    localparam int FLAG_COUNT = 6;
    localparam int FLAG_DATA_PAR = 0;
    localparam int FLAG_SIG_TABORT = 1;
    localparam int FLAG_RCV_TABORT = 2;
    localparam int FLAG_RCV_MABORT = 3;
    localparam int FLAG_SIG_SERR = 4;
    localparam int FLAG_DET_PAR = 5;
    localparam int FLAG_POS [FLAG_COUNT] = '{24, 27, 28, 29, 30, 31};
    // Fixed field values.
    localparam logic [1:0] DEVSEL_MEDIUM = 2'h1;
    localparam logic [7:0] PROG_IF_CODE = 8'h00;
    localparam logic [7:0] SUBCLASS_CODE = 8'h04;
    localparam logic [7:0] BASECLASS_CODE = 8'h06;
    localparam logic [7:0] LINE_SIZE_MAX = 8'h10;
    localparam logic [7:0] LINE_SIZE_RESET = 8'h00;
    localparam logic [7:0] TENURE_RESET = 8'h00;
    localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;
    localparam logic [FLAG_COUNT-1:0] FLAGS_RESET = 6'h00;

    function automatic logic [5:0] dword_of(input logic [7:0] ofs);
        return ofs[7:2];
    endfunction

    function automatic logic [1:0] lane_of(input logic [7:0] ofs);
        return ofs[1:0];
    endfunction
endpackage

// >>> inc/status_evt_if.sv
// Event, clear and flag vectors passed to the sticky status flag keeper.
// Assumes both ends run on the same primary clock.
`timescale 1ns/1ps
interface status_evt_if;
    import bridge_cfg_pkg::*;
    logic [FLAG_COUNT-1:0] set_evt;
    logic [FLAG_COUNT-1:0] clr_mask;
    logic [FLAG_COUNT-1:0] flags;
    modport source (output set_evt, output clr_mask, input flags);
    modport keeper (input set_evt, input clr_mask, output flags);
endinterface

// >>> rtl/status_flags.sv
// Sticky status flags, set by hardware events and cleared by writing one.
// Assumes events and clears arrive as one-cycle pulses on the primary clock.
`timescale 1ns/1ps
module status_flags (
    input wire logic clk_i,
    input wire logic reset_n_i,
    status_evt_if.keeper evt_bus
);
    import bridge_cfg_pkg::*;

    logic [FLAG_COUNT-1:0] flag_reg;
    logic [FLAG_COUNT-1:0] flag_next;

    // An event in the cycle of its clear keeps the flag set.
    assign flag_next = (flag_reg & ~evt_bus.clr_mask) | evt_bus.set_evt;
    assign evt_bus.flags = flag_reg;

    genvar gi;
    generate
        for (gi = 0; gi < FLAG_COUNT; gi++) begin : g_flag
            always_ff @(posedge clk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    flag_reg[gi] <= 1'b0;
                end else begin
                    flag_reg[gi] <= flag_next[gi];
                end
            end
        end
    endgenerate

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    a_set_wins_clear:
        assert property (|evt_bus.set_evt |=> (flag_reg & $past(evt_bus.set_evt)) ==
                         $past(evt_bus.set_evt))
        else $error("status flag lost its setting event");
    a_one_clears_flag:
        assert property (((evt_bus.clr_mask & ~evt_bus.set_evt) != 6'h00) |=>
                         (flag_reg & $past(evt_bus.clr_mask & ~evt_bus.set_evt)) == 6'h00)
        else $error("write of one did not clear status flag");
    a_zero_holds_flag:
        assert property ((evt_bus.clr_mask == 6'h00 && evt_bus.set_evt == 6'h00) |=>
                         $stable(flag_reg))
        else $error("status flag changed without event or clear");
endmodule

// >>> rtl/tenure_timer.sv
// Primary master tenure timer and the end-of-burst decision it drives.
// Assumes the master logic pulses frame start and marks data and line boundaries.
`timescale 1ns/1ps
module tenure_timer #(
    parameter int WIDTH = 8
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [WIDTH-1:0] timer_value_i,
    input wire logic frame_start_i,
    input wire logic master_active_i,
    input wire logic grant_i,
    input wire logic mwi_i,
    input wire logic data_done_i,
    input wire logic line_boundary_i,
    output logic expired_o,
    output logic stop_o
);
    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] count_next;
    logic [WIDTH-1:0] count_now;
    logic at_boundary;

    // The count starts at frame start, one step per clock.
    assign count_now = frame_start_i ? timer_value_i : count_reg;
    assign count_next = (master_active_i && count_now != '0) ? count_now - 1'b1 : count_now;
    // A zero setting counts as expired at once, so the first transfer after grant loss ends it.
    assign expired_o = master_active_i && (count_now == '0);
    // Memory write and invalidate runs on to the line boundary.
    assign at_boundary = mwi_i ? line_boundary_i : data_done_i;
    assign stop_o = expired_o && !grant_i && at_boundary;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    a_stop_needs_grant_loss:
        assert property (stop_o |-> !grant_i && master_active_i && count_now == '0)
        else $error("burst ended with grant held or timer running");
    a_mwi_line_end:
        assert property (stop_o && mwi_i |-> line_boundary_i)
        else $error("invalidate burst ended off a line boundary");
    a_timer_not_early:
        assert property (frame_start_i && master_active_i && timer_value_i == 8'h02 ##1
                         master_active_i |-> !expired_o)
        else $error("tenure timer expired before its programmed count");
endmodule

// >>> bench/cfg_host_model.sv
// Configuration-cycle master that stands in for the primary host.
// Assumes the header acknowledges every request exactly one clock after it is taken.
`timescale 1ns/1ps
module cfg_host_model (
    input wire logic clk_i,
    input wire logic ack_i,
    input wire logic [31:0] rdata_i,
    output logic rd_o,
    output logic wr_o,
    output logic [7:0] addr_o,
    output logic [3:0] be_n_o,
    output logic [31:0] wdata_o
);
    initial begin
        rd_o = 1'b0;
        wr_o = 1'b0;
        addr_o = 8'h00;
        be_n_o = 4'hF;
        wdata_o = 32'h0000_0000;
    end

    // One request per call, never read and write together.
    // Released address, enable and data lines show the inverse of the last value so stale data cannot pass; both strobes drop to zero.
    task automatic access(input logic wr, input logic [7:0] a, input logic [3:0] be_n,
                          input logic [31:0] d, output logic [31:0] q, output logic ok);
        @(posedge clk_i);
        #1;
        rd_o = ~wr;
        wr_o = wr;
        addr_o = a;
        be_n_o = be_n;
        wdata_o = d;
        @(posedge clk_i);
        #1;
        rd_o = 1'b0;
        wr_o = 1'b0;
        addr_o = ~a;
        be_n_o = ~be_n;
        wdata_o = ~d;
        ok = ack_i;
        q = rdata_i;
    endtask
endmodule

// >>> bench/tb_top.sv
// Self-checking bench for the primary configuration header.
// Assumes the host model drives configuration cycles and the bench drives all events.
`timescale 1ns/1ps
module tb_top;
    import bridge_cfg_pkg::*;
    localparam logic [7:0] REV = 8'h03;
    logic clk, rst_n, rd, wr, ack, strap, pen, mst, ok;
    logic fstart, grant, mwi, ddone, lbound, perr_req, serr_req, expired, bstop;
    logic [7:0] addr, ls_eff, v, tv;
    logic [3:0] be_n;
    logic [5:0] ev;
    logic [5:0] f;
    logic [31:0] wdata, rdata, q, rnd, seed;
    int n_errors, total_checks, i;

    cfg_host_model cfg_host_model_i (.clk_i(clk), .ack_i(ack), .rdata_i(rdata), .rd_o(rd),
        .wr_o(wr), .addr_o(addr), .be_n_o(be_n), .wdata_o(wdata));

    bridge_primary_config_header #(.REVISION(REV)) bridge_primary_config_header_i (
        .CLK_SYS_I(clk), .RESET_N_I(rst_n), .CFG_RD_I(rd), .CFG_WR_I(wr),
        .CFG_ADDR_I(addr), .CFG_BE_N_I(be_n), .CFG_WDATA_I(wdata), .CFG_RDATA_O(rdata),
        .CFG_ACK_O(ack), .FAST_CLOCK_STRAP_I(strap), .PARITY_RESP_EN_I(pen),
        .MASTER_ACTIVE_I(mst), .PERR_SEEN_I(ev[0]), .DATA_PERR_I(ev[1]), .ADDR_PERR_I(ev[2]),
        .TGT_ABORT_SENT_I(ev[3]), .TGT_ABORT_RCVD_I(ev[4]), .MST_ABORT_I(ev[5]),
        .FRAME_START_I(fstart), .GRANT_I(grant), .MWI_I(mwi), .DATA_DONE_I(ddone),
        .LINE_BOUNDARY_I(lbound), .PERR_REQ_O(perr_req), .SERR_REQ_O(serr_req),
        .LINE_SIZE_EFF_O(ls_eff), .TENURE_EXPIRED_O(expired), .BURST_STOP_O(bstop));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    function automatic logic [31:0] xorshift();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [31:0] status_word(logic [5:0] fl, logic s);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[BIT_CAP_LIST] = 1'b1;
        w[BIT_FAST_CLOCK] = s;
        w[BIT_FAST_B2B] = 1'b1;
        w[DEVSEL_LSB+:2] = DEVSEL_MEDIUM;
        for (int k = 0; k < FLAG_COUNT; k++) begin
            w[FLAG_POS[k]] = fl[k];
        end
        return w;
    endfunction

    // Event order follows the ev vector wired to the header above.
    function automatic logic [5:0] flags_for(int k, logic en, logic m);
        logic [5:0] fl;
        fl = 6'h00;
        case (k)
            0: fl[FLAG_DATA_PAR] = en & m;
            1: fl = (6'h01 << FLAG_DET_PAR) | (6'(en & m) << FLAG_DATA_PAR);
            2: fl = (6'h01 << FLAG_DET_PAR) | (6'(en) << FLAG_SIG_SERR);
            3: fl[FLAG_SIG_TABORT] = 1'b1;
            4: fl[FLAG_RCV_TABORT] = m;
            default: fl[FLAG_RCV_MABORT] = m;
        endcase
        return fl;
    endfunction

    function automatic logic [7:0] eff_size(logic [7:0] s);
        return (s <= LINE_SIZE_MAX && (s & (s - 8'h01)) == 8'h00) ? s : 8'h00;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rd32(input logic [7:0] a, input logic [31:0] exp);
        cfg_host_model_i.access(1'b0, a, 4'h0, 32'h0, q, ok);
        chk(32'(ok), 32'h1);
        chk(q, exp);
    endtask

    task automatic wr32(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
        cfg_host_model_i.access(1'b1, a, b, d, q, ok);
        chk(32'(ok), 32'h1);
    endtask

    task automatic step();
        @(posedge clk);
        #1;
    endtask

    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        #500000;
        n_errors++;
        $display("watchdog expired at t=%0t", $time);
        end_of_test();
    end

    initial begin
        seed = 32'h5;
        rst_n = 1'b0;
        strap = 1'b1;
        pen = 1'b0;
        mst = 1'b0;
        ev = 6'h00;
        fstart = 1'b0;
        grant = 1'b1;
        mwi = 1'b0;
        ddone = 1'b0;
        lbound = 1'b0;
        repeat (12) @(posedge clk);
        #1;
        rst_n = 1'b1;
        repeat (2) @(posedge clk);
        rd32(OFS_STATUS, status_word(FLAGS_RESET, 1'b1));
        rd32(OFS_REVISION, {BASECLASS_CODE, SUBCLASS_CODE, PROG_IF_CODE, REV});
        rd32(OFS_LINE_SIZE, READ_ZERO);
        wr32(OFS_REVISION, 4'h0, 32'hFFFF_FFFF);
        rd32(OFS_REVISION, {BASECLASS_CODE, SUBCLASS_CODE, PROG_IF_CODE, REV});
        rd32(8'h10, READ_ZERO);
        $display("test reset_and_identity done");

        for (int r = 0; r < 18; r++) begin
            i = r % FLAG_COUNT;
            rnd = xorshift();
            step();
            pen = (r < 6) | (rnd[0] & (r < 12));
            mst = (r < 6) | (r >= 12) | rnd[1];
            strap = rnd[2];
            ev[i] = 1'b1;
            step();
            ev = 6'h00;
            chk({30'h0, perr_req, serr_req}, {30'h0, pen & (i == 1), pen & (i == 2)});
            f = flags_for(i, pen, mst);
            rd32(OFS_STATUS, status_word(f, strap));
            wr32(OFS_STATUS, 4'h7, 32'h0000_0000);
            rd32(OFS_STATUS, status_word(f, strap));
            wr32(OFS_STATUS, 4'h7, status_word(f, 1'b0) & 32'hFF00_0000);
            rd32(OFS_STATUS, status_word(FLAGS_RESET, strap));
        end
        $display("test status_flags done");

        for (int r = 0; r < 24; r++) begin
            rnd = xorshift();
            v = (r < 8) ? (8'h01 << r) : rnd[7:0];
            tv = rnd[15:8];
            wr32(OFS_LINE_SIZE, 4'hC, {16'hFFFF, tv, v});
            chk(32'(ls_eff), 32'(eff_size(v)));
            rd32(OFS_LINE_SIZE, {16'h0000, tv, v});
            wr32(OFS_LINE_SIZE, 4'hE, {16'h0000, ~tv, 8'h11});
            rd32(OFS_LINE_SIZE, {16'h0000, tv, 8'h11});
        end
        $display("test line_size_and_timer_regs done");

        step();
        ev[5] = 1'b1;
        mst = 1'b1;
        step();
        ev = 6'h00;
        rst_n = 1'b0;
        step();
        rst_n = 1'b1;
        repeat (2) @(posedge clk);
        rd32(OFS_STATUS, status_word(FLAGS_RESET, strap));
        rd32(OFS_LINE_SIZE, READ_ZERO);
        $display("test mid_run_reset done");

        for (int r = 0; r < 6; r++) begin
            rnd = xorshift();
            tv = (r == 0) ? TENURE_RESET : (r == 1) ? 8'h02 : {5'h00, rnd[2:0]} + 8'h02;
            wr32(OFS_LINE_SIZE, 4'hD, {16'h0000, tv, 8'h00});
            mst = 1'b1;
            grant = 1'b1;
            fstart = 1'b1;
            step();
            fstart = 1'b0;
            chk(32'(expired), 32'(tv == 8'h00));
            // One count is left just before expiry, so an early expiry shows here.
            if (tv > 8'h01) begin
                repeat (int'(tv) - 2) @(posedge clk);
                #1;
                chk(32'(expired), 32'h0);
            end
            step();
            mwi = r[0];
            ddone = 1'b1;
            #5;
            chk(32'(expired), 32'h1);
            chk(32'(bstop), 32'h0);
            step();
            grant = 1'b0;
            #5;
            chk(32'(bstop), 32'(!mwi));
            step();
            lbound = 1'b1;
            #5;
            chk(32'(bstop), 32'h1);
            step();
            ddone = 1'b0;
            lbound = 1'b0;
            mst = 1'b0;
            grant = 1'b1;
            mwi = 1'b0;
        end
        $display("test tenure_timer done");
        end_of_test();
    end
endmodule
